/* design/twsf_regs.svh */
/*
 * Register offsets, field positions, reset values and counts of the
 * two-wire status-flag block.
 * Assumes inclusion by bare name from the package and the block.
 */
`ifndef TWSF_REGS_SVH
`define TWSF_REGS_SVH

// ============================================================
// Register byte offsets
`define TWSF_OFS_STATUS 8'h00
`define TWSF_OFS_CONTROL 8'h04
`define TWSF_OFS_OWN_ADDR 8'h08
`define TWSF_OFS_IRQ_MASK 8'h0C
`define TWSF_OFS_IRQ_STATUS 8'h10

// ============================================================
// Field positions
`define TWSF_ST_TRANSFER_DONE 7
`define TWSF_ST_ADDRESSED 6
`define TWSF_ST_BUSY 5
`define TWSF_ST_ARB_LOST 4
`define TWSF_ST_DIRECTION 2
`define TWSF_ST_IRQ_PENDING 1
`define TWSF_ST_ACK_SAMPLE 0
`define TWSF_CTL_GENERAL_CALL 0
`define TWSF_CTL_TX_MODE 1
`define TWSF_EV_BYTE 0
`define TWSF_EV_ADDR 1
`define TWSF_EV_ARB 2
`define TWSF_EV_START 3
`define TWSF_EV_STOP 4
`define TWSF_EV_W 5

// ============================================================
// Reset values, codes and counts
`define TWSF_RST_MASK 5'h00
`define TWSF_GENERAL_CALL_ADDR 7'h00
`define TWSF_BITS_PER_BYTE 4'h8
`define TWSF_LAST_BIT 4'h7
`define TWSF_RESP_OKAY 2'h0
`define TWSF_RESP_SLVERR 2'h2

`endif

/* design/twsf_pkg.sv */
/*
 * Types of the two-wire status-flag block: link phase and the one
 * packed state record of the block.
 * Assumes twsf_regs.svh on the include path.
 */
`include "twsf_regs.svh"

package twsf_pkg;

    typedef enum logic [1:0] {
        phase_idle,
        phase_addr,
        phase_data
    } twsf_phase_t;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl;
        logic sda;
    } twsf_pins_t;

    typedef struct packed {
        twsf_pins_t pins;
        twsf_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic transfer_done_flag;
        logic addressed_as_target_flag;
        logic bus_busy_flag;
        logic arbitration_lost_flag;
        logic target_direction_flag;
        logic interrupt_pending_flag;
        logic ack_sample_flag;
        logic general_call_enable;
        logic tx_mode;
        logic [6:0] own_addr;
        logic [`TWSF_EV_W-1:0] irq_mask;
        logic [`TWSF_EV_W-1:0] irq_events;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } twsf_state_t;

endpackage : twsf_pkg

/* design/twsf_status.sv */
/*
 * Status-flag logic of a two-wire serial bus interface, with an
 * AXI4-Lite register slave, bus pin observer and interrupt output.
 * Assumes the rest of the interface drives the data-register access
 * strobes and the arbitration-loss pulse on clk_sys_in, and that the
 * bus pins arrive unsynchronised.
 */
`timescale 1ns/100ps
`include "twsf_regs.svh"

module twsf_status (
    // Clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Two-wire bus pins, observed only
    input wire logic scl_in,
    input wire logic sda_in,
    // Rest of the interface
    input wire logic data_read_strobe_in,
    input wire logic data_write_strobe_in,
    input wire logic arb_lost_in,
    output logic tx_mode_out,
    output logic [7:0] bus_status_out,
    // Interrupt
    output logic irq_out
);

    // ============================================================
    // Helpers

    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        reg_hit = (addr[7:2] == ofs[7:2]);
    endfunction : reg_hit

    function automatic logic [7:0] status_byte(
        input twsf_pkg::twsf_state_t s
    );
        logic [7:0] b;
        b = 8'h00;
        b[`TWSF_ST_TRANSFER_DONE] = s.transfer_done_flag;
        b[`TWSF_ST_ADDRESSED] = s.addressed_as_target_flag;
        b[`TWSF_ST_BUSY] = s.bus_busy_flag;
        b[`TWSF_ST_ARB_LOST] = s.arbitration_lost_flag;
        b[`TWSF_ST_DIRECTION] = s.target_direction_flag;
        b[`TWSF_ST_IRQ_PENDING] = s.interrupt_pending_flag;
        b[`TWSF_ST_ACK_SAMPLE] = s.ack_sample_flag;
        status_byte = b;
    endfunction : status_byte

    function automatic logic mapped(input logic [7:0] addr);
        mapped = reg_hit(addr, `TWSF_OFS_STATUS) ||
            reg_hit(addr, `TWSF_OFS_CONTROL) ||
            reg_hit(addr, `TWSF_OFS_OWN_ADDR) ||
            reg_hit(addr, `TWSF_OFS_IRQ_MASK) ||
            reg_hit(addr, `TWSF_OFS_IRQ_STATUS);
    endfunction : mapped

    // ============================================================
    // State

    twsf_pkg::twsf_state_t r;
    twsf_pkg::twsf_state_t next_r;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;

    assign s_axi_awready_out = ce_in & ~r.aw_held & ~r.bvalid;
    assign s_axi_wready_out = ce_in & ~r.w_held & ~r.bvalid;
    assign s_axi_arready_out = ce_in & ~r.rvalid;
    assign aw_fire = s_axi_awvalid_in & s_axi_awready_out;
    assign w_fire = s_axi_wvalid_in & s_axi_wready_out;
    assign ar_fire = s_axi_arvalid_in & s_axi_arready_out;

    assign s_axi_bvalid_out = r.bvalid;
    assign s_axi_bresp_out = r.bresp;
    assign s_axi_rvalid_out = r.rvalid;
    assign s_axi_rresp_out = r.rresp;
    assign s_axi_rdata_out = {24'h000000, r.rdata};
    assign tx_mode_out = r.tx_mode;
    assign bus_status_out = status_byte(r);
    assign irq_out = |(r.irq_events & r.irq_mask);

    // ============================================================
    // Next-state logic

    always_comb begin
        logic scl_settled;
        logic sda_settled;
        logic scl_rise;
        logic scl_high;
        logic sda_rise;
        logic sda_fall;
        logic start_det;
        logic stop_det;
        logic byte_done;
        logic addr_hit;
        logic [7:0] shifted;
        logic have_aw;
        logic have_w;
        logic do_write;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic wr_en;
        logic [`TWSF_EV_W-1:0] ev;
        scl_settled = 1'b0;
        sda_settled = 1'b0;
        scl_rise = 1'b0;
        scl_high = 1'b0;
        sda_rise = 1'b0;
        sda_fall = 1'b0;
        start_det = 1'b0;
        stop_det = 1'b0;
        byte_done = 1'b0;
        addr_hit = 1'b0;
        shifted = 8'h00;
        have_aw = 1'b0;
        have_w = 1'b0;
        do_write = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        ev = '0;
        next_r = r;

        // Pins: three stages, level taken once stages two and three agree
        next_r.pins.scl_sync = {r.pins.scl_sync[1:0], scl_in};
        next_r.pins.sda_sync = {r.pins.sda_sync[1:0], sda_in};
        scl_settled = (r.pins.scl_sync[1] == r.pins.scl_sync[2]);
        sda_settled = (r.pins.sda_sync[1] == r.pins.sda_sync[2]);
        if (scl_settled) begin
            next_r.pins.scl = r.pins.scl_sync[2];
        end
        if (sda_settled) begin
            next_r.pins.sda = r.pins.sda_sync[2];
        end
        scl_rise = next_r.pins.scl & ~r.pins.scl;
        scl_high = next_r.pins.scl & r.pins.scl;
        sda_rise = next_r.pins.sda & ~r.pins.sda;
        sda_fall = ~next_r.pins.sda & r.pins.sda;
        start_det = scl_high & sda_fall;
        stop_det = scl_high & sda_rise;
        shifted = {r.shift[6:0], next_r.pins.sda};

        // Byte framing on the bus
        if (start_det) begin
            next_r.phase = twsf_pkg::phase_addr;
            next_r.bit_cnt = 4'h0;
            ev[`TWSF_EV_START] = 1'b1;
        end else if (stop_det) begin
            next_r.phase = twsf_pkg::phase_idle;
            ev[`TWSF_EV_STOP] = 1'b1;
        end else if (scl_rise && r.phase != twsf_pkg::phase_idle) begin
            if (r.bit_cnt != `TWSF_BITS_PER_BYTE) begin
                next_r.shift = shifted;
                next_r.bit_cnt = r.bit_cnt + 4'h1;
                if (r.bit_cnt == `TWSF_LAST_BIT &&
                        r.phase == twsf_pkg::phase_addr) begin
                    addr_hit = (shifted[7:1] == r.own_addr) ||
                        (r.general_call_enable &&
                        shifted[7:1] == `TWSF_GENERAL_CALL_ADDR);
                end
            end else begin
                byte_done = 1'b1;
                next_r.bit_cnt = 4'h0;
                next_r.phase = twsf_pkg::phase_data;
                if (r.tx_mode) begin
                    next_r.ack_sample_flag = next_r.pins.sda;
                end
            end
        end

        // Register write path
        have_aw = r.aw_held | aw_fire;
        have_w = r.w_held | w_fire;
        wr_addr = r.aw_held ? r.aw_addr : s_axi_awaddr_in;
        wr_data = r.w_held ? r.w_data : s_axi_wdata_in[7:0];
        if (have_aw && have_w) begin
            do_write = 1'b1;
            wr_en = r.w_held ? r.w_lane0 : s_axi_wstrb_in[0];
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = mapped(wr_addr) ? `TWSF_RESP_OKAY :
                `TWSF_RESP_SLVERR;
        end else begin
            if (aw_fire) begin
                next_r.aw_held = 1'b1;
                next_r.aw_addr = s_axi_awaddr_in;
            end
            if (w_fire) begin
                next_r.w_held = 1'b1;
                next_r.w_data = s_axi_wdata_in[7:0];
                next_r.w_lane0 = s_axi_wstrb_in[0];
            end
        end
        if (r.bvalid && s_axi_bready_in) begin
            next_r.bvalid = 1'b0;
        end
        wr_en = wr_en & do_write;

        // Software clears first, hardware sets below win
        if (wr_en && reg_hit(wr_addr, `TWSF_OFS_CONTROL)) begin
            next_r.general_call_enable = wr_data[`TWSF_CTL_GENERAL_CALL];
            next_r.tx_mode = wr_data[`TWSF_CTL_TX_MODE];
            next_r.addressed_as_target_flag = 1'b0;
        end
        if (wr_en && reg_hit(wr_addr, `TWSF_OFS_OWN_ADDR)) begin
            next_r.own_addr = wr_data[6:0];
        end
        if (wr_en && reg_hit(wr_addr, `TWSF_OFS_IRQ_MASK)) begin
            next_r.irq_mask = wr_data[`TWSF_EV_W-1:0];
        end
        if (wr_en && reg_hit(wr_addr, `TWSF_OFS_IRQ_STATUS)) begin
            next_r.irq_events = r.irq_events & ~wr_data[`TWSF_EV_W-1:0];
        end
        // only two status bits are writable
        if (wr_en && reg_hit(wr_addr, `TWSF_OFS_STATUS)) begin
            if (wr_data[`TWSF_ST_ARB_LOST]) begin
                next_r.arbitration_lost_flag = 1'b0;
            end
            if (wr_data[`TWSF_ST_IRQ_PENDING]) begin
                next_r.interrupt_pending_flag = 1'b0;
            end
        end
        if ((data_read_strobe_in && !r.tx_mode) ||
                (data_write_strobe_in && r.tx_mode)) begin
            next_r.transfer_done_flag = 1'b0;
        end

        // Hardware sets
        // byte finished
        if (byte_done) begin
            next_r.transfer_done_flag = 1'b1;
        end
        if (addr_hit) begin
            next_r.addressed_as_target_flag = 1'b1;
            next_r.target_direction_flag = shifted[0];
        end
        if (start_det) begin
            next_r.bus_busy_flag = 1'b1;
        end else if (stop_det) begin
            next_r.bus_busy_flag = 1'b0;
        end
        if (arb_lost_in) begin
            next_r.arbitration_lost_flag = 1'b1;
        end
        if (byte_done || addr_hit || arb_lost_in) begin
            next_r.interrupt_pending_flag = 1'b1;
        end
        ev[`TWSF_EV_BYTE] = byte_done;
        ev[`TWSF_EV_ADDR] = addr_hit;
        ev[`TWSF_EV_ARB] = arb_lost_in;
        next_r.irq_events = next_r.irq_events | ev;

        // Register read path
        if (ar_fire) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = `TWSF_RESP_OKAY;
            next_r.rdata = 8'h00;
            if (reg_hit(s_axi_araddr_in, `TWSF_OFS_STATUS)) begin
                next_r.rdata = status_byte(r);
            end else if (reg_hit(s_axi_araddr_in,
                    `TWSF_OFS_CONTROL)) begin
                next_r.rdata[`TWSF_CTL_GENERAL_CALL] =
                    r.general_call_enable;
                next_r.rdata[`TWSF_CTL_TX_MODE] = r.tx_mode;
            end else if (reg_hit(s_axi_araddr_in,
                    `TWSF_OFS_OWN_ADDR)) begin
                next_r.rdata = {1'b0, r.own_addr};
            end else if (reg_hit(s_axi_araddr_in,
                    `TWSF_OFS_IRQ_MASK)) begin
                next_r.rdata = {3'h0, r.irq_mask};
            end else if (reg_hit(s_axi_araddr_in,
                    `TWSF_OFS_IRQ_STATUS)) begin
                next_r.rdata = {3'h0, r.irq_events};
            end else begin
                next_r.rresp = `TWSF_RESP_SLVERR;
            end
        end else if (r.rvalid && s_axi_rready_in) begin
            next_r.rvalid = 1'b0;
        end
    end

    // ============================================================
    // Registers

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r <= '0;
            r.pins <= '1;
            r.irq_mask <= `TWSF_RST_MASK;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

endmodule : twsf_status

/* testbench/twsf_checker.sv */
/* Assertions on the ports of the status-flag block.
   Bound from the bench top; single clock domain. */
`timescale 1ns/100ps
module twsf_checker (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // Watched ports
    input wire logic sda_in,
    input wire logic data_read_strobe_in,
    input wire logic data_write_strobe_in,
    input wire logic arb_lost_in,
    input wire logic s_axi_bvalid_out,
    input wire logic tx_mode_out,
    input wire logic [7:0] bus_status_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    logic [7:0] st;
    assign st = bus_status_out;
    // ========
    // Flag relations
    AST_TX_CLR: assert property (ce_in && data_write_strobe_in
        && tx_mode_out && !st[5] |=> !st[7])
        else $error("done kept after data write");
    AST_RX_CLR: assert property (ce_in && data_read_strobe_in
        && !tx_mode_out && !st[5] |=> !st[7])
        else $error("done kept after data read");
    AST_ARB: assert property (ce_in && arb_lost_in
        |=> st[4] && st[1]) else $error("arbitration loss not flagged");
    AST_RSV: assert property (st[3] == 1'h0)
        else $error("bit 3 not zero");
    AST_W1C: assert property ($fell(st[4]) || $fell(st[1])
        |-> $rose(s_axi_bvalid_out)) else $error("flag lost without write");
    AST_ADDR_CLR: assert property ($fell(st[6])
        |-> $rose(s_axi_bvalid_out)) else $error("addressed lost early");
    AST_BUSY: assert property ($fell(st[5]) |-> sda_in)
        else $error("busy cleared without stop");
    AST_DONE: assert property ($rose(st[7]) |-> st[1])
        else $error("byte done without pending");
    AST_MATCH: assert property ($rose(st[6]) |-> st[1])
        else $error("match without pending");
    AST_ACK: assert property ($changed(st[0]) |-> tx_mode_out)
        else $error("ack sample moved in receive");
    AST_DIR: assert property ($changed(st[2]) |-> st[6])
        else $error("direction moved while not addressed");
endmodule : twsf_checker

/* testbench/twsf_bus_model.sv */
/* Two-wire bus controller model driving the observed pins.
   Pins idle high; the link clock stands still between frames. */
`timescale 1ns/100ps
module twsf_bus_model (
    // Bus pins
    output logic scl_out,
    output logic sda_out
);
    // Half of the 80 ns link period
    localparam int HALF = 40;
    initial begin
        scl_out = 1'h1;
        sda_out = 1'h1;
    end
    // Data changes only while the link clock is low
    task automatic put_bit(input logic b);
        sda_out = b;
        #(HALF / 2);
        scl_out = 1'h1;
        #HALF;
        scl_out = 1'h0;
        #(HALF / 2);
    endtask : put_bit
    task automatic put_byte(input logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        put_bit(ack);
    endtask : put_byte
    task automatic frame(input logic [7:0] a, input logic [7:0] d,
            input logic ack);
        sda_out = 1'h0;
        #HALF;
        scl_out = 1'h0;
        #(HALF / 2);
        put_byte(a, ack);
        put_byte(d, ack);
        sda_out = 1'h0;
        #(HALF / 2);
        scl_out = 1'h1;
        #HALF;
        sda_out = 1'h1;
        #HALF;
    endtask : frame
endmodule : twsf_bus_model

/* testbench/two_wire_status_flags_tb_top.sv */
/* Self-checking bench of the status-flag block: register bus master,
   strobes, bus model and a reference of the status byte.
   Assumes design/ on the include path. */
`timescale 1ns/100ps
`include "twsf_regs.svh"
module two_wire_status_flags_tb_top;
    logic clk_sys_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [2:0] stb = 3'h0;
    logic ce = 1'h1;
    logic [3:0] strb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, tx_mode, irq, scl, sda;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd, exp_st, exp_ev, mask;
    logic [7:0] st;
    logic [6:0] own;
    logic ack;
    int error_cnt = 0;
    int checks_done = 0;

    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    twsf_status i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .ce_in(ce), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .scl_in(scl), .sda_in(sda),
        .data_read_strobe_in(stb[0]), .data_write_strobe_in(stb[1]),
        .arb_lost_in(stb[2]), .tx_mode_out(tx_mode),
        .bus_status_out(st), .irq_out(irq));
    twsf_bus_model i_bus (.scl_out(scl), .sda_out(sda));

    // ========
    // Checking and closing
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
        chk(32'(got), 32'(exp));
    endtask : chk_rsp

    // ========
    // Register bus master
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge clk_sys_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_sys_in);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) chk_rsp(bresp, er);
            @(posedge clk_sys_in);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) begin
                bready <= 1'h0;
                return;
            end
        end
        error_cnt++;
        finish_test();
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
            output logic [31:0] v);
        logic ta, tb;
        @(posedge clk_sys_in);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_sys_in);
            ta = arvalid && arready;
            tb = rvalid;
            if (tb) chk_rsp(rresp, er);
            v = rdata;
            @(posedge clk_sys_in);
            if (ta) arvalid <= 1'h0;
            if (tb) begin
                rready <= 1'h0;
                return;
            end
        end
        error_cnt++;
        finish_test();
    endtask : axi_rd

    // ========
    // Stimulus helpers
    task automatic pulse(input logic [2:0] v);
        @(posedge clk_sys_in);
        stb <= v;
        @(posedge clk_sys_in);
        stb <= 3'h0;
    endtask : pulse
    task automatic chk_st();
        axi_rd(`TWSF_OFS_STATUS, 2'h0, rd);
        chk(rd, exp_st);
        // Look at the outputs away from the launching edge
        @(negedge clk_sys_in);
        chk({24'h0, st}, exp_st);
        chk(32'(irq), 32'((exp_ev & mask) != 32'h0));
    endtask : chk_st
    task automatic link(input logic [7:0] a);
        fork
            i_bus.frame(a, 8'($urandom), ack);
            begin
                repeat (30) @(posedge clk_sys_in);
                chk(32'(st[5]), 32'h1);
            end
        join
        repeat (8) @(posedge clk_sys_in);
    endtask : link
    task automatic wr_ctl(input logic [31:0] v);
        axi_wr(`TWSF_OFS_CONTROL, v, 2'h0);
        exp_st = exp_st & 32'hBF;
    endtask : wr_ctl

    // ========
    // Main sequence
    initial begin
        ack = 1'h0;
        rd = $urandom(18309);
        exp_st = 32'h0;
        exp_ev = 32'h0;
        mask = 32'h1F;
        own = 7'($urandom_range(126, 1));
        repeat (4) @(posedge clk_sys_in);
        rst_b_in <= 1'h1;
        chk_st();
        axi_wr(`TWSF_OFS_IRQ_MASK, mask, 2'h0);
        axi_wr(`TWSF_OFS_OWN_ADDR, 32'(own), 2'h0);
        axi_rd(`TWSF_OFS_OWN_ADDR, 2'h0, rd);
        chk(rd, 32'(own));
        axi_wr(8'h20, 32'hFF, 2'h2);
        axi_rd(8'h20, 2'h2, rd);
        chk(rd, 32'h0);
        wr_ctl(32'h2);
        chk(32'(tx_mode), 32'h1);
        // Low byte lane disabled: write must leave the register alone
        strb <= 4'hE;
        axi_wr(`TWSF_OFS_OWN_ADDR, 32'(~own), 2'h0);
        strb <= 4'hF;
        axi_rd(`TWSF_OFS_OWN_ADDR, 2'h0, rd);
        chk(rd, 32'(own));
        // Enable low: a strobe must leave every flag alone
        ce <= 1'h0;
        pulse(3'h4);
        ce <= 1'h1;
        chk_st();
        $display("test registers done");
        for (int k = 0; k < 2; k++) begin
            ack = 1'(k);
            link({own, 1'h0});
            exp_st = 32'hC2 | 32'(ack);
            exp_ev = 32'h1B;
            chk_st();
        end
        pulse(3'h4);
        exp_st = exp_st | 32'h12;
        exp_ev = exp_ev | 32'h4;
        chk_st();
        axi_wr(`TWSF_OFS_STATUS, 32'hFF, 2'h0);
        exp_st = exp_st & 32'hED;
        chk_st();
        mask = 32'h1B;
        axi_wr(`TWSF_OFS_IRQ_MASK, mask, 2'h0);
        axi_wr(`TWSF_OFS_IRQ_STATUS, 32'h1B, 2'h0);
        exp_ev = 32'h4;
        chk_st();
        mask = 32'h1F;
        axi_wr(`TWSF_OFS_IRQ_MASK, mask, 2'h0);
        chk_st();
        axi_wr(`TWSF_OFS_IRQ_STATUS, 32'h4, 2'h0);
        exp_ev = 32'h0;
        chk_st();
        $display("test arbitration and interrupt done");
        wr_ctl(32'h2);
        chk_st();
        pulse(3'h2);
        exp_st = exp_st & 32'h7F;
        chk_st();
        wr_ctl(32'h0);
        // Receive mode: a changed acknowledge must not be sampled
        ack = 1'h0;
        link({own, 1'h0});
        exp_st = (exp_st & 32'h01) | 32'hC2;
        exp_ev = 32'h1B;
        pulse(3'h2);
        chk_st();
        pulse(3'h1);
        exp_st = exp_st & 32'h7F;
        chk_st();
        $display("test done clearing done");
        wr_ctl(32'h1);
        link({`TWSF_GENERAL_CALL_ADDR, 1'h1});
        exp_st = (exp_st & 32'h01) | 32'hC6;
        chk_st();
        wr_ctl(32'h0);
        link({~own, 1'h0});
        chk(32'(st[6]), 32'h0);
        $display("test address match done");
        finish_test();
    end
endmodule : two_wire_status_flags_tb_top

bind twsf_status twsf_checker i_chk (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .ce_in(ce_in), .sda_in(sda_in),
    .data_read_strobe_in(data_read_strobe_in),
    .data_write_strobe_in(data_write_strobe_in),
    .arb_lost_in(arb_lost_in), .s_axi_bvalid_out(s_axi_bvalid_out),
    .tx_mode_out(tx_mode_out), .bus_status_out(bus_status_out));
